// File: hdl/dma_setup_pkg.sv
// Package: register offsets, field positions, reset values and identity constants
package dma_setup_pkg;
  // Configuration space word offsets (byte addresses)
  localparam logic [11:0] CFG_ID_OFFSET     = 12'h000;
  localparam logic [11:0] CFG_SUBID_OFFSET  = 12'h02c;
  localparam logic [11:0] CFG_BAR0_OFFSET   = 12'h010;
  localparam logic [11:0] CFG_BAR1_OFFSET   = 12'h014;
  localparam logic [11:0] CFG_BAR2_OFFSET   = 12'h018;
  localparam logic [11:0] CFG_BAR3_OFFSET   = 12'h01c;
  // Bridge register offsets (byte addresses within window 0/1)
  localparam logic [11:0] LOCAL_RANGE_OFFSET = 12'h000;
  localparam logic [11:0] DMA0_MODE_OFFSET   = 12'h080;
  localparam logic [11:0] DMA1_MODE_OFFSET   = 12'h094;
  localparam logic [11:0] MAILBOX0_OFFSET    = 12'h040;
  localparam logic [11:0] MAILBOX7_OFFSET    = 12'h05c;
  localparam logic [11:0] DOORBELL0_OFFSET   = 12'h060;
  localparam logic [11:0] DOORBELL1_OFFSET   = 12'h064;
  // Local board register offsets (byte addresses within window 2)
  localparam logic [11:0] BOARD_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] PIN_SOURCE_OFFSET   = 12'h040;
  // Local range: 4 KiB window, mask form as the bridge stores it
  localparam logic [31:0] LOCAL_RANGE_4K = 32'hfffff000;
  // Window base type bits: bit0 set means I/O space
  localparam logic [31:0] BAR_MEM_TYPE = 32'h00000000;
  localparam logic [31:0] BAR_IO_TYPE  = 32'h00000001;
  // Channel mode field positions
  localparam int MODE_WIDTH_LSB    = 0;
  localparam int MODE_READY_BIT    = 6;
  localparam int MODE_BURST_BIT    = 8;
  localparam int MODE_CHAIN_BIT    = 9;
  localparam int MODE_CONSTADR_BIT = 11;
  localparam int MODE_DEMAND_BIT   = 12;
  localparam int MODE_STOPSEL_BIT  = 15;
  localparam logic [31:0] MODE_WRITABLE = 32'h0003ffff; // D31:18 reserved
  localparam logic [31:0] MODE_RESET    = 32'h00000000;
  // Pin source termination-disable bit
  localparam int PIN_TERM_OFF_BIT = 30;
  localparam logic [31:0] PIN_SOURCE_RESET = 32'h00000000;
  // Board id jumper count
  localparam int BOARD_ID_BITS = 4;
  // Eeprom identity word indices
  localparam logic [1:0] EE_IDX_ID    = 2'h0;
  localparam logic [1:0] EE_IDX_SUBID = 2'h1;
  localparam logic [1:0] EE_IDX_RANGE = 2'h2;
  localparam logic [1:0] EE_IDX_LAST  = 2'h2;
  // Descriptor word count fetched per chain link
  localparam logic [1:0] DESC_WORDS = 2'h3;
endpackage

// File: hdl/mode_reg.sv
`timescale 1ns/1ps
// One DMA channel mode register with decoded steering outputs
module mode_reg (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_wr,
  input  wire logic [31:0] i_wdata,
  output logic      [31:0] o_value,
  output logic             o_chain,
  output logic             o_demand,
  output logic             o_const_addr,
  output logic             o_wide
);
  // Reserved bits are never stored so they read back as zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_value <= dma_setup_pkg::MODE_RESET;
    end else if (i_wr) begin
      o_value <= i_wdata & dma_setup_pkg::MODE_WRITABLE;
    end
  end

  assign o_chain      = o_value[dma_setup_pkg::MODE_CHAIN_BIT];
  assign o_demand     = o_value[dma_setup_pkg::MODE_DEMAND_BIT];
  assign o_const_addr = o_value[dma_setup_pkg::MODE_CONSTADR_BIT];
  assign o_wide       = &o_value[dma_setup_pkg::MODE_WIDTH_LSB +: 2];
endmodule

// File: hdl/fifo_dma_channel_setup.sv
`timescale 1ns/1ps
// Bridge setup: identity load, windows, local range, DMA mode regs, board status
// Summary of operation
// - Identity and subsystem identity load from eeprom after reset, read only.
// - Window 0 memory, 1 I/O for bridge regs, 2 memory local, 3 unused.
// - Local memory range initialises to four kilobytes.
// - Mailbox and doorbell writes have no board effect.
// - DMA targets only the four FIFO locations, demand or non-demand.
// - Two channels, mode registers at 0x80 and 0x94.
// - Chaining fetches source, destination and count from host memory.
// - Demand mode paces transfers by the demand request signal.
// - Jumper installed reads 1 in status bits 0 to 3.
// - Pin source bit 30 disables built-in transceiver termination.
module fifo_dma_channel_setup #(
  parameter int FIFO_COUNT = 4
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Eeprom load stream: one word per valid, in index order
  input  wire logic        i_ee_valid,
  input  wire logic [31:0] i_ee_data,
  output logic             o_ee_done,
  // Configuration space read port
  input  wire logic        i_cfg_rd,
  input  wire logic [11:0] i_cfg_addr,
  output logic [31:0]      o_cfg_rdata,
  // Bridge register port (window 0 memory or window 1 I/O)
  input  wire logic        i_brg_wr,
  input  wire logic        i_brg_rd,
  input  wire logic [11:0] i_brg_addr,
  input  wire logic [31:0] i_brg_wdata,
  output logic [31:0]      o_brg_rdata,
  // Local board register port (window 2)
  input  wire logic        i_loc_wr,
  input  wire logic        i_loc_rd,
  input  wire logic [11:0] i_loc_addr,
  input  wire logic [31:0] i_loc_wdata,
  output logic [31:0]      o_loc_rdata,
  // Board pins
  input  wire logic [3:0]  i_board_id_header,
  output logic             o_term_disable,
  // DMA engine pacing and descriptor fetch
  input  wire logic [1:0]  i_start,
  input  wire logic [1:0]  i_demand_request_n,
  input  wire logic [1:0]  i_fifo_sel,
  output logic [1:0]       o_xfer_go,
  output logic [1:0]       o_desc_fetch,
  output logic [1:0]       o_desc_word,
  output logic [1:0]       o_fifo_sel_ok,
  output logic [1:0]       o_const_addr
);
  // Elaboration check: the select decode serves exactly four FIFO targets
  if (FIFO_COUNT != 4) begin : g_bad_fifo_count
    $error("FIFO_COUNT must be 4");
  end

  // Identity codes are arbitrary neutral values
  localparam logic [31:0] ID_DEFAULT    = 32'h00015a5a;
  localparam logic [31:0] SUBID_DEFAULT = 32'h00025a5a;

  logic [31:0] id_word;
  logic [31:0] subid_word;
  logic [31:0] local_range;
  logic [1:0]  ee_idx;
  logic [31:0] pin_source;
  logic [31:0] mode_val [2];
  logic [1:0]  chain;
  logic [1:0]  demand;
  logic [1:0]  wide;
  logic [1:0]  desc_busy;
  logic [1:0]  desc_cnt [2];

  // Eeprom load: identity words then local range, after each reset only
  wire ee_take = i_ee_valid && !o_ee_done;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      id_word     <= ID_DEFAULT;
      subid_word  <= SUBID_DEFAULT;
      local_range <= dma_setup_pkg::LOCAL_RANGE_4K;
      ee_idx      <= 2'h0;
      o_ee_done   <= 1'b0;
    end else if (ee_take) begin
      if (ee_idx == dma_setup_pkg::EE_IDX_ID) id_word <= i_ee_data;
      if (ee_idx == dma_setup_pkg::EE_IDX_SUBID) subid_word <= i_ee_data;
      if (ee_idx == dma_setup_pkg::EE_IDX_RANGE) local_range <= i_ee_data;
      ee_idx    <= ee_idx + 2'h1;
      o_ee_done <= (ee_idx == dma_setup_pkg::EE_IDX_LAST);
    end
  end

  // Config reads: identities fixed, windows report their space type
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cfg_rdata <= 32'h0;
    end else if (i_cfg_rd) begin
      case (i_cfg_addr)
        dma_setup_pkg::CFG_ID_OFFSET:    o_cfg_rdata <= id_word;
        dma_setup_pkg::CFG_SUBID_OFFSET: o_cfg_rdata <= subid_word;
        dma_setup_pkg::CFG_BAR0_OFFSET:  o_cfg_rdata <= dma_setup_pkg::BAR_MEM_TYPE;
        dma_setup_pkg::CFG_BAR1_OFFSET:  o_cfg_rdata <= dma_setup_pkg::BAR_IO_TYPE;
        dma_setup_pkg::CFG_BAR2_OFFSET:  o_cfg_rdata <= dma_setup_pkg::BAR_MEM_TYPE;
        default:                         o_cfg_rdata <= 32'h0; // Window 3 reads zero
      endcase
    end
  end

  // Bridge decode; mailbox and doorbell decode to nothing and are dropped
  wire wr_mode0 = i_brg_wr && (i_brg_addr == dma_setup_pkg::DMA0_MODE_OFFSET);
  wire wr_mode1 = i_brg_wr && (i_brg_addr == dma_setup_pkg::DMA1_MODE_OFFSET);

  mode_reg u_mode0 (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_wr         (wr_mode0),
    .i_wdata      (i_brg_wdata),
    .o_value      (mode_val[0]),
    .o_chain      (chain[0]),
    .o_demand     (demand[0]),
    .o_const_addr (o_const_addr[0]),
    .o_wide       (wide[0])
  );
  mode_reg u_mode1 (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_wr         (wr_mode1),
    .i_wdata      (i_brg_wdata),
    .o_value      (mode_val[1]),
    .o_chain      (chain[1]),
    .o_demand     (demand[1]),
    .o_const_addr (o_const_addr[1]),
    .o_wide       (wide[1])
  );

  // Bridge read mux; mailbox/doorbell read zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_brg_rdata <= 32'h0;
    end else if (i_brg_rd) begin
      case (i_brg_addr)
        dma_setup_pkg::DMA0_MODE_OFFSET:   o_brg_rdata <= mode_val[0];
        dma_setup_pkg::DMA1_MODE_OFFSET:   o_brg_rdata <= mode_val[1];
        dma_setup_pkg::LOCAL_RANGE_OFFSET: o_brg_rdata <= local_range;
        default:                           o_brg_rdata <= 32'h0;
      endcase
    end
  end

  // Local board registers: pin source write, status shows jumpers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_source <= dma_setup_pkg::PIN_SOURCE_RESET;
    end else if (i_loc_wr && i_loc_addr == dma_setup_pkg::PIN_SOURCE_OFFSET) begin
      pin_source <= i_loc_wdata;
    end
  end
  assign o_term_disable = pin_source[dma_setup_pkg::PIN_TERM_OFF_BIT];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_loc_rdata <= 32'h0;
    end else if (i_loc_rd) begin
      case (i_loc_addr)
        dma_setup_pkg::BOARD_STATUS_OFFSET: o_loc_rdata <= {28'h0, i_board_id_header};
        dma_setup_pkg::PIN_SOURCE_OFFSET:   o_loc_rdata <= pin_source;
        default:                            o_loc_rdata <= 32'h0;
      endcase
    end
  end

  // Per-channel pacing and descriptor fetch sequencing
  for (genvar c = 0; c < 2; c++) begin : g_ch
    // Only the four FIFO selects exist; packing refused in demand mode
    assign o_fifo_sel_ok[c] = (32'(i_fifo_sel) < FIFO_COUNT) && (wide[c] || !demand[c]);
    // Demand mode gates each beat on the active-low request
    assign o_xfer_go[c] = !desc_busy[c] && o_fifo_sel_ok[c]
                          && (!demand[c] || !i_demand_request_n[c]);
    assign o_desc_fetch[c] = desc_busy[c];
    assign o_desc_word[c]  = desc_cnt[c][0]; // Word index LSB only, one pin per channel
    // Chained start fetches source, destination and count words in turn
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        desc_busy[c] <= 1'b0;
        desc_cnt[c]  <= 2'h0;
      end else if (desc_busy[c]) begin
        desc_cnt[c]  <= desc_cnt[c] + 2'h1;
        desc_busy[c] <= (desc_cnt[c] + 2'h1) != dma_setup_pkg::DESC_WORDS;
      end else if (i_start[c] && chain[c]) begin
        desc_busy[c] <= 1'b1;
        desc_cnt[c]  <= 2'h0;
      end
    end
  end

  // Identity cannot change once loaded
  AST_ID_STABLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_ee_done && $past(o_ee_done) |-> $stable(id_word) && $stable(subid_word))
    else $error("identity changed after load");
  AST_RANGE_RESET: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_ee_done && ee_idx <= dma_setup_pkg::EE_IDX_RANGE
    |-> local_range == dma_setup_pkg::LOCAL_RANGE_4K)
    else $error("local range not 4k before load");
  AST_DOORBELL_INERT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_brg_wr && i_brg_addr >= dma_setup_pkg::MAILBOX0_OFFSET
    && i_brg_addr <= dma_setup_pkg::DOORBELL1_OFFSET
    |=> $stable(mode_val[0]) && $stable(mode_val[1]) && $stable(pin_source))
    else $error("mailbox write changed state");
  AST_MODE_RESERVED: assert property (@(posedge i_clk) disable iff (!i_rstn)
    mode_val[0][31:18] == 14'h0 && mode_val[1][31:18] == 14'h0)
    else $error("reserved mode bits set");
  AST_MODE_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_mode1 |=> mode_val[1] == ($past(i_brg_wdata) & dma_setup_pkg::MODE_WRITABLE))
    else $error("channel 1 mode not written");
  AST_DEMAND_GATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    demand[0] && i_demand_request_n[0] |-> !o_xfer_go[0])
    else $error("demand transfer without request");
  AST_CHAIN_FETCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !desc_busy[0] && i_start[0] && chain[0] |=> desc_busy[0] [*3] ##1 !desc_busy[0])
    else $error("descriptor fetch not three words");
  // Checked against the raw select and mode bits, not the decoded ok wire
  AST_FIFO_ONLY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_xfer_go[1] |-> (32'(i_fifo_sel) < FIFO_COUNT)
    && !(demand[1] && mode_val[1][dma_setup_pkg::MODE_WIDTH_LSB +: 2] == 2'h0))
    else $error("transfer to non-FIFO target");
  AST_BOARD_ID: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_loc_rd && i_loc_addr == dma_setup_pkg::BOARD_STATUS_OFFSET
    |=> o_loc_rdata[3:0] == $past(i_board_id_header))
    else $error("board id mismatch");
  AST_TERM: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_loc_wr && i_loc_addr == dma_setup_pkg::PIN_SOURCE_OFFSET
    |=> o_term_disable == $past(i_loc_wdata[dma_setup_pkg::PIN_TERM_OFF_BIT]))
    else $error("termination disable not following bit 30");
endmodule

// File: test/host_driver_model.sv
`timescale 1ns/1ps
// Host driver model: issues configuration, bridge and local register cycles
module host_driver_model (
  input  wire logic        i_clk,
  output logic             o_cfg_rd,
  output logic [11:0]      o_addr,
  output logic             o_brg_wr,
  output logic             o_brg_rd,
  output logic             o_loc_wr,
  output logic             o_loc_rd,
  output logic [31:0]      o_wdata
);
  // Mode word a driver programs: 32-bit width, ready, burst, fixed address, demand
  localparam logic [31:0] DRV_MODE = 32'h00001943;
  // Idle bus at time zero
  initial begin
    o_cfg_rd = 1'b0;
    o_brg_wr = 1'b0;
    o_brg_rd = 1'b0;
    o_loc_wr = 1'b0;
    o_loc_rd = 1'b0;
    o_addr   = 12'h000;
    o_wdata  = 32'h00000000;
  end
  // One access held for exactly one sampling edge; port 0 cfg, 1 bridge, 2 local
  task automatic acc(input logic [1:0] p, input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    o_cfg_rd <= (p == 2'h0);
    o_brg_wr <= (p == 2'h1) && w;
    o_brg_rd <= (p == 2'h1) && !w;
    o_loc_wr <= (p == 2'h2) && w;
    o_loc_rd <= (p == 2'h2) && !w;
    o_addr   <= a;
    o_wdata  <= d;
    @(posedge i_clk);
    o_cfg_rd <= 1'b0;
    o_brg_wr <= 1'b0;
    o_brg_rd <= 1'b0;
    o_loc_wr <= 1'b0;
    o_loc_rd <= 1'b0;
    // Released lines carry inverted values so stale data never looks valid
    o_addr   <= ~a;
    o_wdata  <= ~d;
    #1;
  endtask
endmodule

// File: test/fifo_dma_channel_setup_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the bridge setup block
module fifo_dma_channel_setup_tb;
  localparam logic [31:0] ID_VAL = 32'h1234abcd;    // Arbitrary identity value
  localparam logic [31:0] SUB_VAL = 32'h5678ef01;   // Arbitrary identity value
  localparam logic [31:0] ONES = 32'hffffffff;
  logic        i_clk, i_rstn, i_ee_valid, ee_done, cfg_rd, brg_wr, brg_rd, loc_wr, loc_rd;
  logic        term_dis;
  logic [11:0] addr;
  logic [31:0] i_ee_data, wdata, cfg_rdata, brg_rdata, loc_rdata;
  logic [31:0] words [4];
  logic [11:0] dead [4];
  logic [3:0]  i_board_id_header;
  logic [1:0]  i_start, i_demand_request_n, i_fifo_sel, go, fetch, dword, sel_ok, cadr;
  int          mismatches, checks_done;

  fifo_dma_channel_setup dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ee_valid(i_ee_valid),
    .i_ee_data(i_ee_data), .o_ee_done(ee_done), .i_cfg_rd(cfg_rd), .i_cfg_addr(addr),
    .o_cfg_rdata(cfg_rdata), .i_brg_wr(brg_wr), .i_brg_rd(brg_rd), .i_brg_addr(addr),
    .i_brg_wdata(wdata), .o_brg_rdata(brg_rdata), .i_loc_wr(loc_wr), .i_loc_rd(loc_rd),
    .i_loc_addr(addr), .i_loc_wdata(wdata), .o_loc_rdata(loc_rdata),
    .i_board_id_header(i_board_id_header), .o_term_disable(term_dis), .i_start(i_start),
    .i_demand_request_n(i_demand_request_n), .i_fifo_sel(i_fifo_sel), .o_xfer_go(go),
    .o_desc_fetch(fetch), .o_desc_word(dword), .o_fifo_sel_ok(sel_ok), .o_const_addr(cadr));
  host_driver_model host (.i_clk(i_clk), .o_cfg_rd(cfg_rd), .o_addr(addr), .o_brg_wr(brg_wr),
    .o_brg_rd(brg_rd), .o_loc_wr(loc_wr), .o_loc_rd(loc_rd), .o_wdata(wdata));

  // 50 ns clock
  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // Read one word and compare the masked bits
  task automatic rd(input logic [1:0] p, input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    host.acc(p, 1'b0, a, 32'h00000000);
    chk(((p == 2'h0) ? cfg_rdata : (p == 2'h1) ? brg_rdata : loc_rdata) & m, e);
  endtask
  task automatic ee(input logic [31:0] d);
    @(posedge i_clk);
    i_ee_valid <= 1'b1;
    i_ee_data  <= d;
    @(posedge i_clk);
    i_ee_valid <= 1'b0;
    i_ee_data  <= ~d;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the roughly 150 cycles the tests need
  initial begin
    repeat (3000) @(posedge i_clk);
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    i_rstn = 1'b0; i_ee_valid = 1'b0; i_ee_data = 32'h0; i_board_id_header = 4'h0;
    i_start = 2'h0; i_demand_request_n = 2'h3; i_fifo_sel = 2'h0;
    words = '{ID_VAL, SUB_VAL, dma_setup_pkg::LOCAL_RANGE_4K, 32'h00000000};
    dead = '{dma_setup_pkg::MAILBOX0_OFFSET, dma_setup_pkg::MAILBOX7_OFFSET,
             dma_setup_pkg::DOORBELL0_OFFSET, dma_setup_pkg::DOORBELL1_OFFSET};
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk({31'h0, ee_done}, 32'h0);
    chk({31'h0, term_dis}, 32'h0);
    rd(2'h1, dma_setup_pkg::DMA0_MODE_OFFSET, ONES, dma_setup_pkg::MODE_RESET);
    rd(2'h1, dma_setup_pkg::DMA1_MODE_OFFSET, ONES, dma_setup_pkg::MODE_RESET);
    $display("test reset done");
    // Fourth word arrives after the load is complete and must be dropped
    for (int i = 0; i < 4; i++) ee(words[i]);
    chk({31'h0, ee_done}, 32'h1);
    rd(2'h0, dma_setup_pkg::CFG_ID_OFFSET, ONES, ID_VAL);
    rd(2'h0, dma_setup_pkg::CFG_SUBID_OFFSET, ONES, SUB_VAL);
    rd(2'h1, dma_setup_pkg::LOCAL_RANGE_OFFSET, ONES, dma_setup_pkg::LOCAL_RANGE_4K);
    rd(2'h0, dma_setup_pkg::CFG_BAR0_OFFSET, 32'h1, dma_setup_pkg::BAR_MEM_TYPE);
    rd(2'h0, dma_setup_pkg::CFG_BAR1_OFFSET, 32'h1, dma_setup_pkg::BAR_IO_TYPE);
    rd(2'h0, dma_setup_pkg::CFG_BAR2_OFFSET, 32'h1, dma_setup_pkg::BAR_MEM_TYPE);
    rd(2'h0, dma_setup_pkg::CFG_BAR3_OFFSET, ONES, 32'h00000000);
    $display("test identity done");
    host.acc(2'h1, 1'b1, dma_setup_pkg::DMA0_MODE_OFFSET, ONES);
    host.acc(2'h1, 1'b1, dma_setup_pkg::DMA1_MODE_OFFSET, host.DRV_MODE);
    for (int i = 0; i < 4; i++) begin
      host.acc(2'h1, 1'b1, dead[i], ONES);
      rd(2'h1, dead[i], ONES, 32'h00000000);
    end
    rd(2'h1, dma_setup_pkg::DMA0_MODE_OFFSET, ONES, dma_setup_pkg::MODE_WRITABLE);
    rd(2'h1, dma_setup_pkg::DMA1_MODE_OFFSET, ONES, host.DRV_MODE);
    chk({30'h0, cadr}, 32'h3);
    $display("test mode registers done");
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      i_board_id_header <= 4'(k);
      rd(2'h2, dma_setup_pkg::BOARD_STATUS_OFFSET, 32'hf, 32'(k));
    end
    host.acc(2'h2, 1'b1, dma_setup_pkg::PIN_SOURCE_OFFSET, 32'h40000000);
    chk({31'h0, term_dis}, 32'h1);
    rd(2'h2, dma_setup_pkg::PIN_SOURCE_OFFSET, 32'h40000000, 32'h40000000);
    host.acc(2'h2, 1'b1, dma_setup_pkg::PIN_SOURCE_OFFSET, 32'h00000000);
    chk({31'h0, term_dis}, 32'h0);
    $display("test board pins done");
    // Chained channel 0: fetch busy for exactly three cycles, channel 1 stays idle
    host.acc(2'h1, 1'b1, dma_setup_pkg::DMA0_MODE_OFFSET, 32'h00001b43);
    @(posedge i_clk);
    i_start <= 2'h1;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_start <= 2'h0;
      #1;
      chk({30'h0, fetch}, (k < 3) ? 32'h1 : 32'h0);
      if (k < 3) chk({31'h0, dword[0]}, 32'(k % 2));
    end
    $display("test chaining done");
    // Both channels in demand mode; channel 0 held unrequested
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_fifo_sel         <= 2'(k);
      i_demand_request_n <= {k[0], 1'b1};
      @(posedge i_clk);
      #1;
      chk({30'h0, go}, {30'h0, ~k[0], 1'b0});
      chk({30'h0, sel_ok}, 32'h3);
    end
    // Eight-bit packing in demand mode moves no data even while both channels request
    @(posedge i_clk);
    i_demand_request_n <= 2'h0;
    host.acc(2'h1, 1'b1, dma_setup_pkg::DMA1_MODE_OFFSET, 32'h00001940);
    chk({30'h0, go}, 32'h1);
    chk({30'h0, sel_ok}, 32'h1);
    $display("test demand done");
    // Second reset mid-run: modes clear and the identity load runs again
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk({31'h0, ee_done}, 32'h0);
    rd(2'h1, dma_setup_pkg::DMA1_MODE_OFFSET, ONES, dma_setup_pkg::MODE_RESET);
    ee(SUB_VAL);
    ee(ID_VAL);
    ee(dma_setup_pkg::LOCAL_RANGE_4K);
    // Done flag settles just after the edge that takes the last word
    #1;
    chk({31'h0, ee_done}, 32'h1);
    rd(2'h0, dma_setup_pkg::CFG_ID_OFFSET, ONES, SUB_VAL);
    rd(2'h0, dma_setup_pkg::CFG_SUBID_OFFSET, ONES, ID_VAL);
    rd(2'h1, dma_setup_pkg::LOCAL_RANGE_OFFSET, ONES, dma_setup_pkg::LOCAL_RANGE_4K);
    $display("test second reset done");
    summarize();
  end
endmodule
